/* File: charger_regs.vh */
`ifndef CHARGER_REGS_VH
`define CHARGER_REGS_VH
// Functional notes
// - battery alone above undervoltage closes battery_switch
// - reset in low power mode, regulator off
// - performance mode keeps gate_drive_regulator on
// - assist entry: both bits clear, pin high
// - fault in assist sets bit, exits mode
// - first droop level triggers input capacitor discharge while assisting
// - second droop level asserts processor_throttle low
// - hold system at minimum regulation point while assisting below first droop level
// - 50 ms after enable level: regulator, good flag
// - qualify 50 ms after undervoltage, retry 2 s
// - converter starts 150 ms, after limits and cells
// - good flag needs input window and no fault, unless set by the port output and its bit
// - good flag rise loads 3.25 A limit
// - applied limit is lower of register, pin
// - floor is unloaded input minus 1.28 V
// - analog supply up: decode cells, load voltage
// - standby on pin low or bit; regulator on
// - port output needs pin, two bits, low input
// - range bit clear adds 1.28 V offset
// - port starts after 10 ms; good flag optional
// - battery overvoltage stops port switching
// register indexes; byte address is four times the index
`define IDX_OPT0 6'h01
`define IDX_VCHG_LO 6'h04
`define IDX_VCHG_HI 6'h05
`define IDX_PORT_V 6'h06
`define IDX_FLOOR 6'h0A
`define IDX_SYSMIN 6'h0D
`define IDX_ILIM 6'h0E
`define IDX_STATUS 6'h20
`define IDX_OPT3 6'h34
`define IDX_OPT4 6'h35
`define IDX_DROOP 6'h36
// field positions
`define OPT0_LOWPWR 7
`define OPT0_PORT_GOOD 3
`define OPT3_ASSIST_OFF 5
`define OPT3_PORT_RANGE 2
`define OPT4_STANDBY 7
`define OPT4_PORT_EN 4
// reset values
`define RST_OPT0 8'h80
`define RST_OPT3 8'h20
`define RST_ILIM 7'h41
// 1.28 V in 64 mV steps
`define OFFS_1V28 8'h14
// charge voltage defaults, mV
`define VCHG_4S 16'h41A0
`define VCHG_3S 16'h3130
`define VCHG_2S 16'h20D0
`define VCHG_1S 16'h1060
// cell ratio boundaries in percent
`define CELL_TH_4S 7'h42
`define CELL_TH_3S 7'h30
`define CELL_TH_2S 7'h21
// timing, ms and cycle rate
`define CLK_HZ 100000000
`define T_GOOD_MS 12'h032
`define T_QUAL_MS 12'h032
`define T_RETRY_MS 12'h7D0
`define T_CONV_MS 12'h096
`define T_PORT_MS 12'h00A
`define MS_CYCLES (`CLK_HZ / 1000)
`endif

/* File: charger_mode_sequencer.v */
`timescale 1ns/100ps
`default_nettype none
`include "charger_regs.vh"
module charger_mode_sequencer #(
  parameter MS_CYCLES = `MS_CYCLES
) (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire bat_above_uvlo,
  input wire vbus_above_uvlo,
  input wire vbus_above_conven,
  input wire vbus_below_disable,
  input wire vbus_above_acov,
  input wire fault_any,
  input wire bat_above_ovp,
  input wire ilim_pin_low,
  input wire analog_supply_ok,
  input wire port_source_enable_pin,
  input wire source_assist_pin,
  input wire [6:0] ilim_pin_code,
  input wire [6:0] cell_ratio_pct,
  input wire [7:0] vbus_code,
  input wire [5:0] sys_volt_code,
  output reg battery_switch,
  output reg gate_drive_regulator,
  output reg input_good_flag,
  output reg converter_on,
  output reg input_standby,
  output reg [6:0] ilim_applied,
  output reg port_active,
  output reg [8:0] port_target,
  output reg assist_active,
  output reg assist_discharge,
  output reg [5:0] sys_hold_target,
  output reg processor_throttle_n
);
  // ==========================================================
  // constants
  localparam NS = 39;
  localparam [11:0] C_GOOD = `T_GOOD_MS;
  localparam [11:0] C_QUAL = `T_QUAL_MS;
  localparam [11:0] C_RETRY = `T_RETRY_MS;
  localparam [11:0] C_CONV = `T_CONV_MS;
  localparam [11:0] C_PORT = `T_PORT_MS;
  localparam [1:0] Q_IDLE = 2'b00;
  localparam [1:0] Q_WAIT = 2'b01;
  localparam [1:0] Q_RETRY = 2'b10;
  localparam [1:0] Q_PASS = 2'b11;
  localparam [2:0] S_OFF = 3'b000;
  localparam [2:0] S_DELAY = 3'b001;
  localparam [2:0] S_LIMITS = 3'b010;
  localparam [2:0] S_START = 3'b011;
  localparam [2:0] S_RUN = 3'b100;

  function [15:0] cell_vchg;
    input [6:0] pct;
    begin
      if (pct >= `CELL_TH_4S)
        cell_vchg = `VCHG_4S;
      else if (pct >= `CELL_TH_3S)
        cell_vchg = `VCHG_3S;
      else if (pct >= `CELL_TH_2S)
        cell_vchg = `VCHG_2S;
      else
        cell_vchg = `VCHG_1S;
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  wire [NS-1:0] pin_raw;
  wire [NS-1:0] pin_sync;
  assign pin_raw = {sys_volt_code, vbus_code, cell_ratio_pct, ilim_pin_code,
    source_assist_pin, port_source_enable_pin, analog_supply_ok, ilim_pin_low,
    bat_above_ovp, fault_any, vbus_above_acov, vbus_below_disable,
    vbus_above_conven, vbus_above_uvlo, bat_above_uvlo};
  // codes are taken bit by bit: they must be quasi-static, a word caught
  // mid-change is off for one cycle
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
      reg meta_r;
      reg stable_r;
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_r <= 1'b0;
          stable_r <= 1'b0;
        end else begin
          meta_r <= pin_raw[gi];
          stable_r <= meta_r;
        end
      end
      assign pin_sync[gi] = stable_r;
    end
  endgenerate
  wire s_bat_ok = pin_sync[0];
  wire s_uvlo = pin_sync[1];
  wire s_conven = pin_sync[2];
  wire s_below_dis = pin_sync[3];
  wire s_acov = pin_sync[4];
  wire s_fault = pin_sync[5];
  wire s_bat_ovp = pin_sync[6];
  wire s_ilim_low = pin_sync[7];
  wire s_analog_ok = pin_sync[8];
  wire s_port_pin = pin_sync[9];
  wire s_assist_pin = pin_sync[10];
  wire [6:0] s_ilim_code = pin_sync[17:11];
  wire [6:0] s_cell_pct = pin_sync[24:18];
  wire [7:0] s_vbus = pin_sync[32:25];
  wire [5:0] s_sys = pin_sync[38:33];

  // ==========================================================
  // millisecond time base
  reg [31:0] div_r;
  reg tick_r;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (div_r >= MS_CYCLES - 1) begin
      div_r <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // ==========================================================
  // registers
  reg [7:0] opt0_r;
  reg [7:0] opt3_r;
  reg [7:0] opt4_r;
  reg [7:0] droop_r;
  reg [5:0] sysmin_r;
  reg [6:0] ilim_r;
  reg [7:0] port_v_r;
  reg [15:0] vchg_r;
  reg [7:0] floor_r;
  reg [1:0] qst_r;
  reg [2:0] seq_r;
  reg qual_fail_r;
  reg cell_done_r;
  wire [5:0] idx = avs_address[7:2];
  wire wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];
  wire good_cond = s_conven && !s_acov && !s_fault;
  wire good_rise;
  wire assist_fault = assist_active && s_fault;
  reg [7:0] rd_nxt;

  always @* begin
    case (idx)
      `IDX_OPT0: rd_nxt = opt0_r;
      `IDX_VCHG_LO: rd_nxt = vchg_r[7:0];
      `IDX_VCHG_HI: rd_nxt = vchg_r[15:8];
      `IDX_PORT_V: rd_nxt = port_v_r;
      `IDX_FLOOR: rd_nxt = floor_r;
      `IDX_SYSMIN: rd_nxt = {2'b00, sysmin_r};
      `IDX_ILIM: rd_nxt = {1'b0, ilim_r};
      `IDX_STATUS: rd_nxt = {input_good_flag, converter_on, input_standby,
        port_active, assist_active, qual_fail_r, cell_done_r, battery_switch};
      `IDX_OPT3: rd_nxt = opt3_r;
      `IDX_OPT4: rd_nxt = opt4_r;
      `IDX_DROOP: rd_nxt = droop_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  // one wait cycle per access, then the answer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else if (avs_waitrequest && (avs_read || avs_write)) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= {24'h0, rd_nxt};
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      opt0_r <= `RST_OPT0;
      opt3_r <= `RST_OPT3;
      opt4_r <= 8'h00;
      droop_r <= 8'h00;
      sysmin_r <= 6'h00;
      port_v_r <= 8'h00;
    end else begin
      if (wr_go && idx == `IDX_OPT0)
        opt0_r <= wd;
      if (wr_go && idx == `IDX_OPT4)
        opt4_r <= wd;
      if (wr_go && idx == `IDX_DROOP)
        droop_r <= wd;
      if (wr_go && idx == `IDX_SYSMIN)
        sysmin_r <= wd[5:0];
      if (wr_go && idx == `IDX_PORT_V)
        port_v_r <= wd;
      if (wr_go && idx == `IDX_OPT3)
        opt3_r <= wd;
      // hardware set wins over a host clear in the same cycle
      if (assist_fault)
        opt3_r[`OPT3_ASSIST_OFF] <= 1'b1;
    end
  end

  // input limit: power-up default wins over a host write
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      ilim_r <= `RST_ILIM;
    else if (good_rise)
      ilim_r <= `RST_ILIM;
    else if (wr_go && idx == `IDX_ILIM)
      ilim_r <= wd[6:0];
  end

  // ==========================================================
  // input qualification and power-up from a source
  reg [11:0] qcnt_r;
  reg [11:0] ccnt_r;
  reg uvlo_d_r;
  reg good_d_r;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      qst_r <= Q_IDLE;
      qcnt_r <= 12'h0;
      qual_fail_r <= 1'b0;
      uvlo_d_r <= 1'b0;
    end else begin
      uvlo_d_r <= s_uvlo;
      case (qst_r)
        Q_IDLE: begin
          qcnt_r <= 12'h0;
          if (s_uvlo && !uvlo_d_r)
            qst_r <= Q_WAIT;
        end
        Q_WAIT, Q_RETRY: begin
          if (!s_uvlo) begin
            qst_r <= Q_IDLE;
          end else if (tick_r) begin
            qcnt_r <= qcnt_r + 12'h1;
            if (qcnt_r + 12'h1 >= (qst_r == Q_WAIT ? C_QUAL : C_RETRY)) begin
              qcnt_r <= 12'h0;
              qual_fail_r <= !s_conven;
              qst_r <= s_conven ? Q_PASS : Q_RETRY;
            end
          end
        end
        Q_PASS: begin
          if (!s_uvlo)
            qst_r <= Q_IDLE;
        end
        default: qst_r <= Q_IDLE;
      endcase
    end
  end

  wire qual_ok = (qst_r == Q_PASS);
  wire good_time = (ccnt_r >= C_GOOD) && qual_ok;
  assign good_rise = input_good_flag && !good_d_r;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_r <= S_OFF;
      ccnt_r <= 12'h0;
      cell_done_r <= 1'b0;
      vchg_r <= `VCHG_1S;
      floor_r <= 8'h00;
      good_d_r <= 1'b0;
    end else begin
      good_d_r <= input_good_flag;
      if (!s_conven)
        ccnt_r <= 12'h0;
      else if (tick_r && ccnt_r < C_CONV)
        ccnt_r <= ccnt_r + 12'h1;
      if (s_analog_ok && !cell_done_r) begin
        vchg_r <= cell_vchg(s_cell_pct);
        cell_done_r <= 1'b1;
      end
      case (seq_r)
        S_OFF:
          if (s_conven)
            seq_r <= S_DELAY;
        S_DELAY:
          if (!s_conven)
            seq_r <= S_OFF;
          else if (good_time)
            seq_r <= S_LIMITS;
        S_LIMITS:
          if (!s_conven)
            seq_r <= S_OFF;
          else if (ccnt_r >= C_CONV && cell_done_r)
            seq_r <= S_START;
        S_START: begin
          floor_r <= (s_vbus > `OFFS_1V28) ? s_vbus - `OFFS_1V28 : 8'h00;
          seq_r <= S_RUN;
        end
        S_RUN:
          if (!s_conven)
            seq_r <= S_OFF;
        default: seq_r <= S_OFF;
      endcase
    end
  end

  // ==========================================================
  // port output and minimum-voltage assist
  reg [11:0] pcnt_r;
  wire assist_off = opt3_r[`OPT3_ASSIST_OFF];
  wire port_en = opt4_r[`OPT4_PORT_EN];
  wire port_cond = s_port_pin && port_en && assist_off && s_below_dis;
  wire assist_cond = !assist_off && !port_en && s_assist_pin;
  wire standby_now = s_ilim_low || opt4_r[`OPT4_STANDBY];
  wire [5:0] th_assist = {droop_r[7:4], 2'b00};
  wire [5:0] th_throttle = {droop_r[3:2], 4'h0};
  wire src_run = (seq_r == S_RUN);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pcnt_r <= 12'h0;
      port_active <= 1'b0;
    end else if (!port_cond) begin
      pcnt_r <= 12'h0;
      port_active <= 1'b0;
    end else if (tick_r && pcnt_r < C_PORT) begin
      pcnt_r <= pcnt_r + 12'h1;
    end else if (pcnt_r >= C_PORT) begin
      port_active <= 1'b1;
    end
  end

  // ==========================================================
  // outputs
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      battery_switch <= 1'b0;
      gate_drive_regulator <= 1'b0;
      input_good_flag <= 1'b0;
      converter_on <= 1'b0;
      input_standby <= 1'b0;
      ilim_applied <= `RST_ILIM;
      port_target <= 9'h000;
      assist_active <= 1'b0;
      assist_discharge <= 1'b0;
      sys_hold_target <= 6'h00;
      processor_throttle_n <= 1'b1;
    end else begin
      // battery feeds the system whenever it is healthy
      battery_switch <= s_bat_ok;
      gate_drive_regulator <= !opt0_r[`OPT0_LOWPWR] || good_time || src_run ||
        port_active || assist_active;
      input_good_flag <= (good_cond && good_time) ||
        (port_active && opt0_r[`OPT0_PORT_GOOD]);
      input_standby <= standby_now && s_uvlo;
      converter_on <= (src_run && !standby_now) ||
        (port_active && !s_bat_ovp) || assist_active;
      ilim_applied <= (ilim_r < s_ilim_code) ? ilim_r : s_ilim_code;
      port_target <= opt3_r[`OPT3_PORT_RANGE] ? {1'b0, port_v_r} :
        {1'b0, port_v_r} + {1'b0, `OFFS_1V28};
      assist_active <= assist_cond && !assist_fault;
      assist_discharge <= assist_cond && (s_sys < th_assist);
      sys_hold_target <= (assist_cond && (s_sys < th_assist)) ? sysmin_r : 6'h00;
      processor_throttle_n <= !(s_sys < th_throttle);
    end
  end
endmodule
`default_nettype wire

/* File: charger_seq_props.sv */
`timescale 1ns/100ps
`default_nettype none
module charger_seq_checker #(
  parameter MS_CYCLES = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic bat_above_uvlo,
  input wire logic vbus_above_uvlo,
  input wire logic vbus_above_conven,
  input wire logic vbus_below_disable,
  input wire logic vbus_above_acov,
  input wire logic fault_any,
  input wire logic source_assist_pin,
  input wire logic port_source_enable_pin,
  input wire logic battery_switch,
  input wire logic input_good_flag,
  input wire logic port_active,
  input wire logic assist_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ====
  // raw cycle counts of the qualifying levels
  logic [31:0] port_cnt_r;
  logic [31:0] good_cnt_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_cnt_r <= 32'h0;
      good_cnt_r <= 32'h0;
    end else begin
      port_cnt_r <= (port_source_enable_pin && vbus_below_disable) ? port_cnt_r + 32'h1 : 32'h0;
      good_cnt_r <= vbus_above_conven ? good_cnt_r + 32'h1 : 32'h0;
    end
  end
  // ====
  // properties; delays keep one ms of slack since the tick phase is free
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  good_window_a: assert property ((fault_any || vbus_above_acov || !vbus_above_conven) [*5]
    |-> !input_good_flag || port_active) else $error("good flag outside window");
  good_delay_a: assert property ($rose(input_good_flag) && !port_active
    |-> good_cnt_r >= 49 * MS_CYCLES) else $error("good flag early");
  bat_switch_a: assert property ((bat_above_uvlo && !vbus_above_uvlo) [*5] |-> battery_switch)
    else $error("battery switch open");
  assist_pin_a: assert property (!source_assist_pin [*5] |-> !assist_active)
    else $error("assist without pin");
  port_pin_a: assert property ((!port_source_enable_pin || !vbus_below_disable) [*5]
    |-> !port_active) else $error("port without conditions");
  port_delay_a: assert property ($rose(port_active) |-> port_cnt_r >= 9 * MS_CYCLES)
    else $error("port early");
  cover property ($rose(input_good_flag));
  cover property ($rose(port_active));
  cover property ($rose(assist_active));
endmodule
bind charger_mode_sequencer charger_seq_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .bat_above_uvlo(bat_above_uvlo),
  .vbus_above_uvlo(vbus_above_uvlo), .vbus_above_conven(vbus_above_conven),
  .vbus_below_disable(vbus_below_disable), .vbus_above_acov(vbus_above_acov),
  .fault_any(fault_any), .source_assist_pin(source_assist_pin),
  .port_source_enable_pin(port_source_enable_pin), .battery_switch(battery_switch),
  .input_good_flag(input_good_flag), .port_active(port_active),
  .assist_active(assist_active)
);
`default_nettype wire

/* File: power_stage_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ====
// input comparators; codes are arbitrary, disable sits below enable for hysteresis
module power_stage_model #(
  parameter UVLO_CODE = 8'h32,
  parameter DISABLE_CODE = 8'h38,
  parameter CONVEN_CODE = 8'h3C,
  parameter ACOV_CODE = 8'hC0
) (
  input wire logic [7:0] vbus_code,
  output logic vbus_above_uvlo,
  output logic vbus_above_conven,
  output logic vbus_below_disable,
  output logic vbus_above_acov
);
  assign vbus_above_uvlo = vbus_code > UVLO_CODE;
  assign vbus_above_conven = vbus_code > CONVEN_CODE;
  assign vbus_below_disable = vbus_code < DISABLE_CODE;
  assign vbus_above_acov = vbus_code > ACOV_CODE;
endmodule
`default_nettype wire

/* File: charger_mode_sequencer_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "charger_regs.vh"
module charger_mode_sequencer_test;
  localparam int MS = 10;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'h0, avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic bat_above_uvlo = 1'h0, fault_any = 1'h0, bat_above_ovp = 1'h0, ilim_pin_low = 1'h0;
  logic analog_supply_ok = 1'h0, port_source_enable_pin = 1'h0, source_assist_pin = 1'h0;
  logic [6:0] ilim_pin_code = 7'h7F, cell_ratio_pct = 7'h00;
  logic [7:0] vbus_code = 8'h00;
  logic [5:0] sys_volt_code = 6'h3F;
  wire [31:0] avs_readdata;
  wire [6:0] ilim_applied;
  wire [8:0] port_target;
  wire [5:0] sys_hold_target;
  wire avs_waitrequest, battery_switch, gate_drive_regulator, input_good_flag, converter_on;
  wire input_standby, port_active, assist_active, assist_discharge, processor_throttle_n;
  wire vbus_above_uvlo, vbus_above_conven, vbus_below_disable, vbus_above_acov;
  int n_errors = 0;
  int comparisons = 0;
  logic [7:0] pc, vb;
  logic [5:0] sm;
  logic [6:0] pct [4] = '{7'h4B, 7'h37, 7'h28, 7'h19};
  logic [15:0] mv [4] = '{16'h41A0, 16'h3130, 16'h20D0, 16'h1060};
  charger_mode_sequencer #(.MS_CYCLES(MS)) u_dut (.*);
  power_stage_model u_stage (.*);
  always #5 clk = ~clk;
  // ====
  // helpers
  function automatic logic [8:0] port_exp(input logic [7:0] c, input logic rng);
    return rng ? {1'h0, c} : {1'h0, c} + {1'h0, `OFFS_1V28};
  endfunction
  function automatic logic [6:0] ilim_min(input logic [6:0] a, input logic [6:0] b);
    return (a < b) ? a : b;
  endfunction
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge clk);
    avs_address <= {idx, 2'h0};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, wd};
    @(posedge clk);
    while (avs_waitrequest !== 1'h0) @(posedge clk);
    rd = avs_readdata[7:0];
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'h1, idx, d, x);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input string nm, input logic [5:0] idx, input logic [15:0] e);
    logic [7:0] d;
    bus(1'h0, idx, 8'h00, d);
    chk(nm, e, {8'h00, d});
  endtask
  task automatic ms(input int n);
    repeat (n * MS) @(posedge clk);
  endtask
  // pin levels pass two sync flops and an output flop
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask
  task automatic do_reset;
    sys_rst <= 1'h1;
    vbus_code <= 8'h00;
    analog_supply_ok <= 1'h0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
  endtask
  task automatic end_sim;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ====
  // scenarios
  initial begin
    void'($urandom(32'hBFA7));
    do_reset();
    rdchk("opt0", `IDX_OPT0, 16'h0080);
    rdchk("opt3", `IDX_OPT3, 16'h0020);
    rdchk("ilim", `IDX_ILIM, 16'h0041);
    rdchk("unmapped", 6'h3F, 16'h0000);
    chk("regulator", 16'h0, gate_drive_regulator);
    wr(`IDX_OPT0, 8'h00);
    bat_above_uvlo <= 1'h1;
    settle();
    chk("regulator", 16'h1, gate_drive_regulator);
    chk("bat switch", 16'h1, battery_switch);
    sm = 6'($urandom_range(63));
    wr(`IDX_SYSMIN, {2'h0, sm});
    wr(`IDX_DROOP, 8'hFC);
    wr(`IDX_OPT3, 8'h00);
    wr(`IDX_OPT4, 8'h00);
    source_assist_pin <= 1'h1;
    settle();
    chk("assist", 16'h1, assist_active);
    chk("discharge", 16'h0, assist_discharge);
    chk("throttle_n", 16'h1, processor_throttle_n);
    chk("sys hold", 16'h0000, sys_hold_target);
    sys_volt_code <= 6'($urandom_range(47));
    settle();
    chk("discharge", 16'h1, assist_discharge);
    chk("throttle_n", 16'h0, processor_throttle_n);
    chk("sys hold", {10'h0, sm}, sys_hold_target);
    fault_any <= 1'h1;
    settle();
    fault_any <= 1'h0;
    chk("assist", 16'h0, assist_active);
    rdchk("opt3", `IDX_OPT3, 16'h0020);
    wr(`IDX_OPT3, 8'h00);
    settle();
    chk("assist", 16'h1, assist_active);
    source_assist_pin <= 1'h0;
    settle();
    chk("assist", 16'h0, assist_active);
    pc = 8'($urandom_range(255));
    wr(`IDX_PORT_V, pc);
    wr(`IDX_OPT3, 8'h20);
    wr(`IDX_OPT4, 8'h10);
    port_source_enable_pin <= 1'h1;
    ms(9);
    chk("port early", 16'h0, port_active);
    ms(3);
    chk("port", 16'h1, port_active);
    chk("converter", 16'h1, converter_on);
    chk("good", 16'h0, input_good_flag);
    chk("target", {7'h0, port_exp(pc, 1'h0)}, port_target);
    wr(`IDX_OPT0, 8'h08);
    wr(`IDX_OPT3, 8'h24);
    settle();
    chk("good", 16'h1, input_good_flag);
    chk("target", {7'h0, port_exp(pc, 1'h1)}, port_target);
    bat_above_ovp <= 1'h1;
    settle();
    chk("converter", 16'h0, converter_on);
    bat_above_ovp <= 1'h0;
    port_source_enable_pin <= 1'h0;
    // input between the undervoltage and enable levels fails qualification
    do_reset();
    vbus_code <= 8'h36;
    ms(55);
    rdchk("status", `IDX_STATUS, 16'h0005);
    vbus_code <= 8'h50;
    ms(100);
    chk("good no retry", 16'h0, input_good_flag);
    ms(1880);
    chk("good no retry", 16'h0, input_good_flag);
    ms(40);
    chk("good retried", 16'h1, input_good_flag);
    for (int i = 0; i < 4; i++) begin
      do_reset();
      wr(`IDX_ILIM, 8'h10);
      ilim_pin_code <= 7'($urandom_range(127));
      analog_supply_ok <= 1'h1;
      cell_ratio_pct <= pct[i];
      vb = 8'($urandom_range(8'hB0, 8'h40));
      vbus_code <= vb;
      ms(45);
      chk("good early", 16'h0, input_good_flag);
      ms(10);
      chk("good", 16'h1, input_good_flag);
      chk("regulator", 16'h1, gate_drive_regulator);
      rdchk("ilim", `IDX_ILIM, 16'h0041);
      chk("ilim used", {9'h0, ilim_min(7'h41, ilim_pin_code)}, ilim_applied);
      ms(88);
      chk("conv early", 16'h0, converter_on);
      ms(10);
      chk("converter", 16'h1, converter_on);
      rdchk("chg lo", `IDX_VCHG_LO, {8'h00, mv[i][7:0]});
      rdchk("chg hi", `IDX_VCHG_HI, {8'h00, mv[i][15:8]});
      rdchk("floor", `IDX_FLOOR, {8'h00, vb - `OFFS_1V28});
      if (i[0]) wr(`IDX_OPT4, 8'h80);
      else ilim_pin_low <= 1'h1;
      settle();
      chk("standby", 16'h1, input_standby);
      chk("regulator", 16'h1, gate_drive_regulator);
      ilim_pin_low <= 1'h0;
      fault_any <= 1'h1;
      settle();
      chk("good", 16'h0, input_good_flag);
      fault_any <= 1'h0;
    end
    end_sim();
  end
  // the run needs about 28000 cycles; over double that before calling it a hang
  initial begin
    #700000;
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
